/* include/ffs_cfg.svh */
// register indices, field positions and codes of the frame status block
`ifndef FFS_CFG_SVH
`define FFS_CFG_SVH

// register indices (byte address = index * 4)
`define FFS_IDX_FRAME_ADDR   4'h1
`define FFS_IDX_RX_CNT_LO    4'h2
`define FFS_IDX_RX_CNT_HI    4'h3
`define FFS_IDX_TX_STATUS    4'h5
`define FFS_IDX_RX_CTRL      4'h6
`define FFS_IDX_RX_STAT_CMD  4'h7
`define FFS_IDX_TX_CTRL      4'h8
`define FFS_IDX_TX_LEVEL     4'h9

// transmit status bits
`define FFS_TS_UNDERRUN      3
`define FFS_TS_END_OF_MSG    2
`define FFS_TS_FIFO_READY    1
`define FFS_TS_EARLY_EOM     0

// receive control bits
`define FFS_RC_LEVEL_HALF    7
`define FFS_RC_CRC_EN        6
`define FFS_RC_AMODE_HI      5
`define FFS_RC_AMODE_LO      4
`define FFS_RC_SH_IE         3
`define FFS_RC_READY_IE      1
`define FFS_RC_SPECIAL_IE    0
`define FFS_RC_MASK          8'hfb

// receive status bits
`define FFS_RS_ABORT         7
`define FFS_RS_FRAME_ERR     6
`define FFS_RS_OVERRUN       5
`define FFS_RS_END_OF_FRAME  4
`define FFS_RS_DATA_AVAIL    3
`define FFS_RS_SYNC_HUNT     2

// transmit control bits
`define FFS_TC_READY_IE      6
`define FFS_TC_URN_EOM_IE    5
`define FFS_TC_AUTO_EOM      2
`define FFS_TC_MASK          8'h64
`define FFS_TL_MODE_4M       7
`define FFS_TL_MASK          8'h87

// command field and frame address layout
`define FFS_CMD_HI           7
`define FFS_CMD_LO           4
`define FFS_FA_MASK          8'hfe
`define FFS_UNIVERSAL_ADDR   8'h7f

// fifo thresholds, early-eom base count, abort limits
`define FFS_RX_THR_HALF      5'h08
`define FFS_RX_THR_ONE       5'h01
`define FFS_EARLY_BASE       13'h0008
`define FFS_ONES_ABORT       3'h7
`define FFS_ZERO_SYM_ABORT   2'h2
`define FFS_SYM_ZERO         4'h0

`endif

/* include/ffs_pkg.sv */
// types shared by the frame status block
package ffs_pkg;

  typedef enum logic [1:0] {
    FFS_AM_ALL    = 2'h0,
    FFS_AM_FULL   = 2'h1,
    FFS_AM_NIBBLE = 2'h2,
    FFS_AM_RSVD   = 2'h3
  } ffs_amode_type;

  typedef enum logic [3:0] {
    FFS_CMD_NONE      = 4'h0,
    FFS_CMD_HUNT      = 4'h1,
    FFS_CMD_RX_PTR    = 4'h2,
    FFS_CMD_RX_SPEC   = 4'h3,
    FFS_CMD_RING_PTR  = 4'h4,
    FFS_CMD_URN_EOM   = 4'h5,
    FFS_CMD_TX_PTR    = 4'h6,
    FFS_CMD_HW_RESET  = 4'h7
  } ffs_cmd_type;

  // gray along hunt -> sync -> hunt
  typedef enum logic {
    FFS_SH_HUNT = 1'b0,
    FFS_SH_SYNC = 1'b1
  } ffs_sh_type;

endpackage

/* design/ffs_abort_det.sv */
// receive abort detector for both link rates
`timescale 1ns/1ps
`default_nettype none
`include "ffs_cfg.svh"

module ffs_abort_det
  import ffs_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // rate and framing
  input  wire logic       i_mode_4m,
  input  wire logic       i_start_flag,
  input  wire logic       i_stop_flag,
  // 1 Mbit bit stream
  input  wire logic       i_bit_valid,
  input  wire logic       i_bit,
  // 4 Mbit symbol stream
  input  wire logic       i_sym_valid,
  input  wire logic [3:0] i_sym,
  input  wire logic       i_sym_illegal,
  input  wire logic       i_sym_in_stop,
  // result
  output logic            o_abort
);

  logic [2:0] ones_r;
  logic [1:0] zeros_r;
  logic       in_frame_r;
  logic       seen_flag_r;
  logic       zero_sym;
  logic       abort_1m;
  logic       abort_4m;

  assign zero_sym = i_sym_valid && (i_sym == `FFS_SYM_ZERO);

  // ----------------------------------------------------------------
  // 1 Mbit: run of ones
  // ----------------------------------------------------------------
  // RL11: seven ones abort
  assign abort_1m = !i_mode_4m && i_bit_valid && i_bit &&
                    (ones_r == (`FFS_ONES_ABORT - 3'h1));

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_start_flag) begin
      ones_r <= 3'h0;
    end else if (i_bit_valid) begin
      if (!i_bit) begin
        ones_r <= 3'h0;
      end else if (ones_r != `FFS_ONES_ABORT) begin
        ones_r <= ones_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // 4 Mbit: zero symbols inside a frame, illegal symbols outside a stop flag after the first start flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      in_frame_r  <= 1'b0;
      seen_flag_r <= 1'b0;
    end else if (i_start_flag) begin
      in_frame_r  <= 1'b1;
      seen_flag_r <= 1'b1;
    end else if (i_stop_flag) begin
      in_frame_r  <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_start_flag) begin
      zeros_r <= 2'h0;
    end else if (zero_sym && in_frame_r && zeros_r != `FFS_ZERO_SYM_ABORT) begin
      zeros_r <= zeros_r + 2'h1;
    end
  end

  // RL12: second zero symbol, or stray illegal symbol
  assign abort_4m = i_mode_4m &&
    ((zero_sym && in_frame_r &&
      (zeros_r == (`FFS_ZERO_SYM_ABORT - 2'h1))) ||
     (i_sym_valid && i_sym_illegal && !i_sym_in_stop && seen_flag_r));

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_abort <= 1'b0;
    end else begin
      o_abort <= abort_1m || abort_4m;
    end
  end

endmodule
`default_nettype wire

/* design/ffs_core.sv */
// frame status and control registers with classic wishbone slave
//
// Functional notes
// RL1: underrun flag while empty with bytes left
// RL2: end of message after crc and flag
// RL3: auto-clear end of message on status read
// RL4: fifo ready flag, interrupt on rise
// RL5: early eom at level, cleared on read
// RL6: rx control bit 7 picks threshold
// RL7: crc errors reported only when enabled
// RL8: address mode selects frame filter
// RL9: universal address always accepted
// RL10: rx control bits gate interrupts
// RL11: 1 Mbit abort on seven ones
// RL12: 4 Mbit abort on illegal symbols
// RL13: frame error set, cleared at start
// RL14: overrun when fifo overflows
// RL15: end of frame, cleared at start
// RL16: data available, poll only, no threshold
// RL17: sync/hunt change flag on state change
// RL18: read clears change flag or shows state
// RL19: command codes trigger reset actions
// RL20: command field clears itself
// RL21: frame address bits 7-1, bit 0 zero
// RL22: 13-bit rx byte count, low/high
// RL23: reserved bits read zero, ignore writes
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ffs_cfg.svh"

module ffs_core
  import ffs_pkg::*;
#(
  parameter int CNT_W  = 13,
  parameter int FIFO_W = 5
)(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  // wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [5:0]        i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  // transmit side
  input  wire logic              i_tx_active,
  input  wire logic              i_tx_fifo_empty,
  input  wire logic              i_tx_fifo_full,
  input  wire logic [CNT_W-1:0]  i_tx_byte_count,
  input  wire logic              i_tx_msg_done,
  // receive framing
  input  wire logic              i_rx_start_flag,
  input  wire logic              i_rx_stop_flag,
  input  wire logic              i_rx_preamble,
  input  wire logic              i_rx_crc_err,
  input  wire logic              i_rx_align_err,
  input  wire logic              i_rx_bit_valid,
  input  wire logic              i_rx_bit,
  input  wire logic              i_rx_sym_valid,
  input  wire logic [3:0]        i_rx_sym,
  input  wire logic              i_rx_sym_illegal,
  input  wire logic              i_rx_sym_in_stop,
  // receive address and fifo
  input  wire logic              i_rx_addr_valid,
  input  wire logic [7:0]        i_rx_addr,
  input  wire logic              i_rx_fifo_push,
  input  wire logic              i_rx_fifo_full,
  input  wire logic [FIFO_W-1:0] i_rx_fifo_level,
  // filter and threshold
  output logic                   o_frame_accept,
  output logic                   o_frame_reject,
  output logic                   o_rx_threshold,
  // command pulses
  output logic                   o_enter_hunt,
  output logic                   o_rx_fifo_ptr_rst,
  output logic                   o_ring_ptr_rst,
  output logic                   o_tx_fifo_ptr_rst,
  output logic                   o_hw_reset,
  // interrupt requests
  output logic                   o_tx_special_irq,
  output logic                   o_tx_ready_irq,
  output logic                   o_rx_ready_irq,
  output logic                   o_rx_special_irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       ack_r;
  logic       access;
  logic       wr_hit;
  logic       rd_hit;
  logic [3:0] idx;
  logic [7:0] wdat;

  function automatic logic reg_is(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  assign access = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr_hit = access && i_wb_we && i_wb_sel[0];
  assign rd_hit = access && !i_wb_we;
  assign idx    = i_wb_adr[5:2];
  assign wdat   = i_wb_dat[7:0];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  ffs_cmd_type cmd_r;
  logic        soft_rst;
  logic        rst_all;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cmd_r <= FFS_CMD_NONE;
    end else if (wr_hit && reg_is(idx, `FFS_IDX_RX_STAT_CMD)) begin
      cmd_r <= ffs_cmd_type'(wdat[`FFS_CMD_HI:`FFS_CMD_LO]);
    end else begin
      // RL20: self-clearing command
      cmd_r <= FFS_CMD_NONE;
    end
  end

  // RL19: command code actions
  assign soft_rst          = (cmd_r == FFS_CMD_HW_RESET);
  assign rst_all           = i_sys_rst || soft_rst;
  assign o_enter_hunt      = (cmd_r == FFS_CMD_HUNT);
  assign o_rx_fifo_ptr_rst = (cmd_r == FFS_CMD_RX_PTR);
  assign o_ring_ptr_rst    = (cmd_r == FFS_CMD_RING_PTR);
  assign o_tx_fifo_ptr_rst = (cmd_r == FFS_CMD_TX_PTR);
  assign o_hw_reset        = soft_rst;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] frame_addr_r;
  logic [7:0] rx_ctrl_r;
  logic [7:0] tx_ctrl_r;
  logic [7:0] tx_level_r;

  // RL21: bit 0 never stored
  // RL23: reserved bits masked on write
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      frame_addr_r <= 8'h00;
      rx_ctrl_r    <= 8'h00;
      tx_ctrl_r    <= 8'h00;
      tx_level_r   <= 8'h00;
    end else if (wr_hit) begin
      if (reg_is(idx, `FFS_IDX_FRAME_ADDR)) begin
        frame_addr_r <= wdat & `FFS_FA_MASK;
      end
      if (reg_is(idx, `FFS_IDX_RX_CTRL)) begin
        rx_ctrl_r <= wdat & `FFS_RC_MASK;
      end
      if (reg_is(idx, `FFS_IDX_TX_CTRL)) begin
        tx_ctrl_r <= wdat & `FFS_TC_MASK;
      end
      if (reg_is(idx, `FFS_IDX_TX_LEVEL)) begin
        tx_level_r <= wdat & `FFS_TL_MASK;
      end
    end
  end

  logic          mode_4m;
  ffs_amode_type amode;
  logic          rd_tx_stat;
  logic          rd_rx_stat;

  assign mode_4m    = tx_level_r[`FFS_TL_MODE_4M];
  assign amode      = ffs_amode_type'(rx_ctrl_r[`FFS_RC_AMODE_HI:`FFS_RC_AMODE_LO]);
  assign rd_tx_stat = rd_hit && reg_is(idx, `FFS_IDX_TX_STATUS);
  assign rd_rx_stat = rd_hit && reg_is(idx, `FFS_IDX_RX_STAT_CMD);

  // ----------------------------------------------------------------
  // transmit status
  // ----------------------------------------------------------------
  logic             underrun_r;
  logic             eom_r;
  logic             early_r;
  logic             ready_prev_r;
  logic [CNT_W-1:0] tx_cnt_prev_r;
  logic [CNT_W-1:0] early_target;
  logic             urn_eom_clr;
  logic             tx_ready;
  logic             urn_set;
  logic             early_set;

  assign urn_eom_clr  = (cmd_r == FFS_CMD_URN_EOM);
  assign tx_ready     = !i_tx_fifo_full;
  // RL1: empty fifo while bytes remain
  assign urn_set      = i_tx_active && i_tx_fifo_empty && (i_tx_byte_count != '0);
  // level n selects a count of 8 << n
  assign early_target = CNT_W'(`FFS_EARLY_BASE << tx_level_r[2:0]);
  // RL5: count reaches early level
  assign early_set    = (tx_level_r[2:0] != 3'h0) &&
                        (i_tx_byte_count == early_target) &&
                        (tx_cnt_prev_r != early_target);

  // set wins over every clear below
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      underrun_r <= 1'b0;
    end else if (urn_set) begin
      underrun_r <= 1'b1;
    end else if (urn_eom_clr) begin
      underrun_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      eom_r <= 1'b0;
    // RL2: set after crc and closing flag
    end else if (i_tx_msg_done) begin
      eom_r <= 1'b1;
    // RL3: read clears only with auto-clear on
    end else if (urn_eom_clr ||
                 (rd_tx_stat && tx_ctrl_r[`FFS_TC_AUTO_EOM])) begin
      eom_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      early_r       <= 1'b0;
      tx_cnt_prev_r <= '0;
    end else begin
      tx_cnt_prev_r <= i_tx_byte_count;
      if (early_set) begin
        early_r <= 1'b1;
      end else if (rd_tx_stat) begin
        early_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      ready_prev_r   <= 1'b0;
      o_tx_ready_irq <= 1'b0;
    end else begin
      ready_prev_r   <= tx_ready;
      // RL4: pulse on each rising ready
      o_tx_ready_irq <= tx_ready && !ready_prev_r &&
                        tx_ctrl_r[`FFS_TC_READY_IE];
    end
  end

  assign o_tx_special_irq = tx_ctrl_r[`FFS_TC_URN_EOM_IE] &&
                            (underrun_r || eom_r || early_r);

  // ----------------------------------------------------------------
  // receive status
  // ----------------------------------------------------------------
  logic       abort_det;
  logic       abort_r;
  logic       frame_err_r;
  logic       overrun_r;
  logic       eof_r;
  logic       sh_chg_r;
  ffs_sh_type sh_r;
  ffs_sh_type sh_nxt;
  logic       spec_clr;
  logic       frame_err_set;

  ffs_abort_det u_abort (
    .i_ref_clk     (i_ref_clk),
    .i_sys_rst     (rst_all),
    .i_mode_4m     (mode_4m),
    .i_start_flag  (i_rx_start_flag),
    .i_stop_flag   (i_rx_stop_flag),
    .i_bit_valid   (i_rx_bit_valid),
    .i_bit         (i_rx_bit),
    .i_sym_valid   (i_rx_sym_valid),
    .i_sym         (i_rx_sym),
    .i_sym_illegal (i_rx_sym_illegal),
    .i_sym_in_stop (i_rx_sym_in_stop),
    .o_abort       (abort_det)
  );

  assign spec_clr      = (cmd_r == FFS_CMD_RX_SPEC);
  // RL7: crc errors dropped when checking off
  assign frame_err_set = i_rx_align_err ||
                         (i_rx_crc_err && rx_ctrl_r[`FFS_RC_CRC_EN]);

  // RL11: abort flag
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      abort_r <= 1'b0;
    end else if (abort_det) begin
      abort_r <= 1'b1;
    end else if (spec_clr) begin
      abort_r <= 1'b0;
    end
  end

  // RL13: frame error, start flag clears
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      frame_err_r <= 1'b0;
    end else if (frame_err_set) begin
      frame_err_r <= 1'b1;
    end else if (spec_clr || i_rx_start_flag) begin
      frame_err_r <= 1'b0;
    end
  end

  // RL14: push into a full fifo
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      overrun_r <= 1'b0;
    end else if (i_rx_fifo_push && i_rx_fifo_full) begin
      overrun_r <= 1'b1;
    end else if (spec_clr) begin
      overrun_r <= 1'b0;
    end
  end

  // RL15: closing flag or abort
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      eof_r <= 1'b0;
    end else if (i_rx_stop_flag || abort_det) begin
      eof_r <= 1'b1;
    end else if (spec_clr || i_rx_start_flag) begin
      eof_r <= 1'b0;
    end
  end

  // RL17: sync/hunt tracking
  always_comb begin
    sh_nxt = sh_r;
    unique case (sh_r)
      FFS_SH_HUNT: begin
        if (i_rx_start_flag || (mode_4m && i_rx_preamble)) begin
          sh_nxt = FFS_SH_SYNC;
        end
      end
      FFS_SH_SYNC: begin
        if (o_enter_hunt || i_rx_stop_flag) begin
          sh_nxt = FFS_SH_HUNT;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      sh_r <= FFS_SH_HUNT;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      sh_chg_r <= 1'b0;
    end else if (sh_nxt != sh_r) begin
      sh_chg_r <= 1'b1;
    // RL18: read clears only with interrupt on
    end else if (rd_rx_stat && rx_ctrl_r[`FFS_RC_SH_IE]) begin
      sh_chg_r <= 1'b0;
    end
  end

  // RL10: interrupt gating
  assign o_rx_special_irq =
    (rx_ctrl_r[`FFS_RC_SPECIAL_IE] &&
     (abort_r || frame_err_r || overrun_r || eof_r)) ||
    (rx_ctrl_r[`FFS_RC_SH_IE] && sh_chg_r);

  // RL6: threshold selection
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      o_rx_threshold <= 1'b0;
    end else if (rx_ctrl_r[`FFS_RC_LEVEL_HALF]) begin
      o_rx_threshold <= i_rx_fifo_level > FIFO_W'(`FFS_RX_THR_HALF);
    end else begin
      o_rx_threshold <= i_rx_fifo_level > FIFO_W'(`FFS_RX_THR_ONE);
    end
  end

  assign o_rx_ready_irq = rx_ctrl_r[`FFS_RC_READY_IE] && o_rx_threshold;

  // ----------------------------------------------------------------
  // address filter and byte count
  // ----------------------------------------------------------------
  logic             addr_ok;
  logic [CNT_W-1:0] rx_cnt_r;

  always_comb begin
    addr_ok = 1'b0;
    unique case (amode)
      // RL8: filter modes
      FFS_AM_ALL:    addr_ok = 1'b1;
      FFS_AM_FULL:   addr_ok = i_rx_addr[7:1] == frame_addr_r[7:1];
      FFS_AM_NIBBLE: addr_ok = i_rx_addr[7:4] == frame_addr_r[7:4];
      FFS_AM_RSVD:   addr_ok = 1'b0;
    endcase
    // RL9: universal address
    if (i_rx_addr == `FFS_UNIVERSAL_ADDR) begin
      addr_ok = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      o_frame_accept <= 1'b0;
      o_frame_reject <= 1'b0;
    end else begin
      o_frame_accept <= i_rx_addr_valid && addr_ok;
      o_frame_reject <= i_rx_addr_valid && !addr_ok;
    end
  end

  // RL22: running count, restarts per packet
  always_ff @(posedge i_ref_clk) begin
    if (rst_all || i_rx_start_flag) begin
      rx_cnt_r <= '0;
    end else if (i_rx_fifo_push) begin
      rx_cnt_r <= rx_cnt_r + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] rd_val;

  // RL23: reserved and unmapped read zero
  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      `FFS_IDX_FRAME_ADDR: rd_val = frame_addr_r;
      `FFS_IDX_RX_CNT_LO:  rd_val = rx_cnt_r[7:0];
      `FFS_IDX_RX_CNT_HI:  rd_val = {3'h0, rx_cnt_r[CNT_W-1:8]};
      `FFS_IDX_TX_STATUS: begin
        rd_val[`FFS_TS_UNDERRUN]   = underrun_r;
        rd_val[`FFS_TS_END_OF_MSG] = eom_r;
        rd_val[`FFS_TS_FIFO_READY] = tx_ready;
        rd_val[`FFS_TS_EARLY_EOM]  = early_r;
      end
      `FFS_IDX_RX_CTRL:    rd_val = rx_ctrl_r;
      `FFS_IDX_RX_STAT_CMD: begin
        rd_val[`FFS_RS_ABORT]        = abort_r;
        rd_val[`FFS_RS_FRAME_ERR]    = frame_err_r;
        rd_val[`FFS_RS_OVERRUN]      = overrun_r;
        rd_val[`FFS_RS_END_OF_FRAME] = eof_r;
        // RL16: poll-only, ignores threshold
        rd_val[`FFS_RS_DATA_AVAIL]   = i_rx_fifo_level != '0;
        rd_val[`FFS_RS_SYNC_HUNT]    = rx_ctrl_r[`FFS_RC_SH_IE] ?
                                       sh_chg_r : (sh_r == FFS_SH_SYNC);
      end
      `FFS_IDX_TX_CTRL:    rd_val = tx_ctrl_r;
      `FFS_IDX_TX_LEVEL:   rd_val = tx_level_r;
      default:             rd_val = 8'h00;
    endcase
  end

  // one wait state: ack in the cycle after the request
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ack_r    <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_r <= access;
      if (rd_hit) begin
        o_wb_dat <= {24'h00_0000, rd_val};
      end
    end
  end

  assign o_wb_ack = ack_r;

endmodule
`default_nettype wire

/* dv/ffs_sva.sv */
// port assertions of the frame status block
`timescale 1ns/1ps
`default_nettype none
module ffs_sva #(parameter int FIFO_W = 5) (
  // bus
  input wire logic              i_ref_clk, i_sys_rst,
  input wire logic              i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
  input wire logic [5:0]        i_wb_adr,
  input wire logic [3:0]        i_wb_sel,
  input wire logic [31:0]       i_wb_dat, o_wb_dat,
  // receive side and commands
  input wire logic              i_rx_addr_valid, o_frame_accept,
  input wire logic              o_frame_reject, o_rx_threshold,
  input wire logic [7:0]        i_rx_addr,
  input wire logic [FIFO_W-1:0] i_rx_fifo_level,
  input wire logic              o_enter_hunt, o_rx_fifo_ptr_rst,
  input wire logic              o_ring_ptr_rst, o_tx_fifo_ptr_rst,
  input wire logic              o_hw_reset
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic req;
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  property p_ack; req |=> o_wb_ack ##1 !o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_rsvd; o_wb_ack |-> o_wb_dat[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper data set");
  property p_univ; i_rx_addr_valid && i_rx_addr == 8'h7f |=> o_frame_accept;
  endproperty
  a_univ: assert property (p_univ) else $error("universal dropped");
  property p_filt; i_rx_addr_valid |=> o_frame_accept != o_frame_reject;
  endproperty
  a_filt: assert property (p_filt) else $error("filter verdict bad");
  property p_thr_lo; i_rx_fifo_level <= 1 |=> !o_rx_threshold; endproperty
  a_thr_lo: assert property (p_thr_lo) else $error("threshold early");
  property p_thr_hi; i_rx_fifo_level > 8 |=> o_rx_threshold; endproperty
  a_thr_hi: assert property (p_thr_hi) else $error("threshold missed");
  property p_cmd;
    req && i_wb_we && i_wb_sel[0] && i_wb_adr[5:2] == 4'h7 &&
      i_wb_dat[7:4] == 4'h1 |-> ##[1:2] o_enter_hunt ##1 !o_enter_hunt;
  endproperty
  a_cmd: assert property (p_cmd) else $error("hunt pulse bad");
  property p_one;
    $onehot0({o_enter_hunt, o_rx_fifo_ptr_rst, o_ring_ptr_rst,
              o_tx_fifo_ptr_rst, o_hw_reset});
  endproperty
  a_one: assert property (p_one) else $error("two commands at once");
endmodule
`default_nettype wire

/* dv/ffs_modem_model.sv */
// modem stand-in driving receive framing pulses, bits and address
`timescale 1ns/1ps
`default_nettype none
module ffs_modem_model (
  // clock
  input  wire logic i_ref_clk,
  // pulses: start stop crc push addr bit
  output logic [5:0] o_pl,
  output logic       o_bit,
  output logic [7:0] o_addr
);
  initial begin
    o_pl = 6'h0;
    o_bit = 1'b0;
    o_addr = 8'h0;
  end
  // released address shows the inverse, not a stale value
  task pl(input logic [5:0] v, input logic [7:0] a);
    @(posedge i_ref_clk);
    o_pl <= v;
    o_addr <= a;
    @(posedge i_ref_clk);
    o_pl <= 6'h0;
    o_addr <= ~a;
  endtask
  task ones(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      o_pl <= 6'h20;
      o_bit <= 1'b1;
    end
    @(posedge i_ref_clk);
    o_pl <= 6'h0;
    o_bit <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/tb_ffs_core.sv */
// self-checking bench of the frame status block
`timescale 1ns/1ps
`default_nettype none
module tb_ffs_core import ffs_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic txa = 1'b0, txe = 1'b0, txf = 1'b0, done = 1'b0, rxf = 1'b0;
  logic [5:0]  adr = 6'h0, pl;
  logic [3:0]  sel = 4'h1;
  logic [31:0] wd = 32'h0, rd, dat;
  logic [12:0] tc = 13'h0;
  logic [4:0]  lvl = 5'h0, seen = 5'h0, pu;
  logic [7:0]  ma;
  logic        ack, acc, rej, thr, mb;
  int          error_cnt = 0, total_checks = 0;
  // mode, address, accepted
  logic [10:0] ft [6] = '{{2'h0, 8'h12, 1'b1}, {2'h1, 8'ha5, 1'b1},
    {2'h1, 8'ha6, 1'b0}, {2'h2, 8'ha6, 1'b1}, {2'h2, 8'hb4, 1'b0},
    {2'h3, 8'h7f, 1'b1}};
  // half-level select, fill level, threshold
  logic [6:0] tt [4] = '{{1'b1, 5'h09, 1'b1}, {1'b1, 5'h08, 1'b0},
    {1'b0, 5'h02, 1'b1}, {1'b0, 5'h01, 1'b0}};
  ffs_core i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wd), .o_wb_dat(dat), .o_wb_ack(ack), .i_tx_active(txa),
    .i_tx_fifo_empty(txe), .i_tx_fifo_full(txf), .i_tx_byte_count(tc),
    .i_tx_msg_done(done), .i_rx_start_flag(pl[0]), .i_rx_stop_flag(pl[1]),
    .i_rx_preamble(1'b0), .i_rx_crc_err(pl[2]), .i_rx_align_err(1'b0),
    .i_rx_bit_valid(pl[5]), .i_rx_bit(mb), .i_rx_sym_valid(1'b0),
    .i_rx_sym(4'h0), .i_rx_sym_illegal(1'b0), .i_rx_sym_in_stop(mb),
    .i_rx_addr_valid(pl[4]), .i_rx_addr(ma), .i_rx_fifo_push(pl[3]),
    .i_rx_fifo_full(rxf), .i_rx_fifo_level(lvl), .o_frame_accept(acc),
    .o_frame_reject(rej), .o_rx_threshold(thr), .o_enter_hunt(pu[0]),
    .o_rx_fifo_ptr_rst(pu[1]), .o_ring_ptr_rst(pu[2]),
    .o_tx_fifo_ptr_rst(pu[3]), .o_hw_reset(pu[4]), .o_tx_special_irq(),
    .o_tx_ready_irq(), .o_rx_ready_irq(), .o_rx_special_irq());
  ffs_modem_model m (.i_ref_clk(clk), .o_pl(pl), .o_bit(mb), .o_addr(ma));
  initial forever #10 clk = ~clk;
  always @(posedge clk) seen <= seen | pu;
  // request held until ack is seen high at a rising edge
  task bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wd <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task rdc(input logic [3:0] i, input logic [7:0] e, input logic [7:0] k = 8'hff);
    bus(1'b0, i, 8'h0);
    chk($sformatf("reg %h", i), e, rd[7:0] & k);
  endtask
  task tx_done;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(3, 8'h00); rdc(5, 8'h02); rdc(7, 8'h00);
    rdc(4'hf, 8'h00); bus(1, 1, 8'hff); rdc(1, 8'hfe);
    sel <= 4'h0; bus(1, 1, 8'h00); sel <= 4'h1; rdc(1, 8'hfe);
    bus(1, 6, 8'hff); rdc(6, 8'hfb);
    bus(1, 1, 8'ha4);
    foreach (ft[k]) begin
      bus(1, 6, {2'h0, ft[k][10:9], 4'h0});
      m.pl(6'h10, ft[k][8:1]);
      @(negedge clk);
      chk("accept", {7'h0, ft[k][0]}, {7'h0, acc});
    end
    @(posedge clk); $display("test registers and filter end");
    txa <= 1'b1; txe <= 1'b1; tc <= 13'h5;
    tx_done();
    txa <= 1'b0;
    rdc(5, 8'h0e); rdc(5, 8'h0e);
    bus(1, 7, {FFS_CMD_URN_EOM, 4'h0}); rdc(5, 8'h02);
    bus(1, 8, 8'h04); tx_done(); rdc(5, 8'h06); rdc(5, 8'h02);
    bus(1, 9, 8'h01); tc <= 13'h11; @(posedge clk); tc <= 13'h10;
    rdc(5, 8'h03); rdc(5, 8'h02);
    txf <= 1'b1; rdc(5, 8'h00); txf <= 1'b0;
    $display("test transmit end");
    bus(1, 6, 8'h00); m.pl(6'h01, 8'h0); rdc(7, 8'h04);
    m.pl(6'h04, 8'h0); m.pl(6'h02, 8'h0); rdc(7, 8'h10);
    bus(1, 6, 8'h40); m.pl(6'h01, 8'h0);
    repeat (3) m.pl(6'h08, 8'h0);
    rdc(2, 8'h03); rdc(3, 8'h00);
    m.pl(6'h04, 8'h0); rxf <= 1'b1; m.pl(6'h08, 8'h0); rxf <= 1'b0;
    rdc(7, 8'h64);
    bus(1, 7, {FFS_CMD_RX_SPEC, 4'h0}); rdc(7, 8'h04);
    m.ones(7); repeat (2) @(posedge clk); rdc(7, 8'h80, 8'h80);
    bus(1, 6, 8'h08); m.pl(6'h02, 8'h0);
    rdc(7, 8'h04, 8'h04); rdc(7, 8'h00, 8'h04);
    foreach (tt[k]) begin
      bus(1, 6, {tt[k][6], 7'h0}); lvl <= tt[k][5:1];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("threshold", {7'h0, tt[k][0]}, {7'h0, thr});
    end
    rdc(7, 8'h08, 8'h08);
    $display("test receive end");
    bus(1, 6, 8'h42);
    for (int c = 1; c < 8; c++) bus(1, 7, {c[3:0], 4'h0});
    @(negedge clk); chk("commands", 8'h1f, {3'h0, seen});
    rdc(6, 8'h00); $display("test commands end");
    give_verdict();
  end
endmodule
bind ffs_core ffs_sva #(.FIFO_W(FIFO_W)) u_sva (.*);
`default_nettype wire
